// [logic/isr_pkg.sv]
// Package: offsets, fields and reset values for the interrupt status and terminal address registers
package isr_pkg;
	// ==========================================================
	// Register byte offsets on APB
	localparam logic [7:0] ISR_OFF_HP_EN = 8'h1c;
	localparam logic [7:0] ISR_OFF_HP_CAUSE = 8'h20;
	localparam logic [7:0] ISR_OFF_STD_EN = 8'h24;
	localparam logic [7:0] ISR_OFF_TADDR = 8'h28;
	// ==========================================================
	// Cause bit positions
	localparam int ISR_B_STD = 0;
	localparam int ISR_B_MSGERR = 1;
	localparam int ISR_B_ENDCB = 2;
	localparam int ISR_B_STFAIL = 3;
	localparam int ISR_B_ENDST = 4;
	localparam int ISR_B_SSFAIL = 5;
	localparam int ISR_B_DBC = 6;
	localparam int ISR_B_ILLOG = 7;
	localparam int ISR_B_OVR = 8;
	// Standard event enable positions
	localparam int ISR_S_ICBC = 0;
	localparam int ISR_S_MSGERR = 1;
	localparam int ISR_S_RETRY = 2;
	localparam int ISR_S_POLL = 3;
	localparam int ISR_S_ILLCMD = 4;
	localparam int ISR_S_ILLBC = 5;
	// Terminal address register positions
	localparam int ISR_T_INSTR = 15;
	localparam int ISR_T_BUSY = 14;
	localparam int ISR_T_SSF = 13;
	localparam int ISR_T_DBCA = 12;
	localparam int ISR_T_TF = 11;
	localparam int ISR_T_SRQ = 10;
	localparam int ISR_T_BUSYX = 9;
	localparam int ISR_T_ROLE = 8;
	localparam int ISR_T_LOCK = 7;
	localparam int ISR_T_PERR = 6;
	localparam int ISR_T_PAR = 5;
	// ==========================================================
	// Widths and reset values
	localparam logic [15:0] ISR_HP_MASK = 16'h01ff;
	localparam logic [15:0] ISR_STD_MASK = 16'h003f;
	localparam logic [15:0] ISR_HP_EN_RST = 16'h0000;
	localparam logic [15:0] ISR_STD_EN_RST = 16'h0000;
	localparam logic [15:0] ISR_TADDR_RST = 16'h0000;
	typedef struct packed {
		logic instr;
		logic busy;
		logic ss_flag;
		logic dbc_accept;
		logic term_flag;
		logic srq;
		logic block_xfer;
	} isr_status_s;
	typedef struct packed {
		logic illegal_bcast;
		logic illegal_cmd;
		logic poll_match;
		logic poll_cb_en;
		logic retry_fail;
		logic msg_error;
		logic icb_done;
		logic cb_std;
		logic desc_std;
	} isr_std_ev_s;
endpackage

// [logic/isr_regs.sv]
// Interrupt cause, standard event enable and terminal address register bank
`timescale 1ns/1ps
// Summary of operation
// - Standard enable clear: only std pin asserts
// - Cause register holds cause, write-one clears
// - Cause bits 8..1 fixed events, upper reserved
// - Std enables gate logging, descriptors also log
// - RT illegal broadcast/illegal command enables
// - Poll match needs command block bit 12
// - Retry fail interrupt after all retries
// - Message error enable in all modes
// - Interrupt-and-continue block done enable
// - Bits 15,10 drive instrumentation, service request
// - Bit 14 busy, transfers still allowed
// - Bit 9 busy, transfers blocked
// - Bit 13 subsystem flag, logged in RT
// - Bit 12 dynamic bus control acceptance
// - Bit 11 terminal flag, also self-test fail
// - Bit 8 mirrors role select pin
// - Bit 7 mirrors lock pin, blocks address changes
// - Bit 5 odd parity, bit 6 error
// - Bits 4-0 address from pins at reset
module isr_regs
	import isr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [8:1] hp_event,
	input wire isr_std_ev_s std_ev,
	input wire logic rt_mode,
	input wire logic bc_mode,
	input wire logic mon_mode,
	input wire logic dbc_code_rx,
	input wire logic selftest_fail,
	input wire logic addr_latch,
	input wire logic role_select_pin,
	input wire logic lock_pin,
	input wire logic [4:0] terminal_addr_pins,
	input wire logic terminal_par_pin,
	output logic std_irq_n_pin,
	output logic hp_irq_n,
	output logic std_log,
	output logic ss_fail_log,
	output isr_status_s status_flags,
	output logic [4:0] terminal_addr
);
	// ==========================================================
	// Bus decode
	logic wr_acc;
	logic setup_acc;
	logic hit_en;
	logic hit_cause;
	logic hit_std;
	logic hit_ta;
	logic ok;
	assign wr_acc = psel & penable & pwrite;
	assign setup_acc = psel & ~penable;
	assign hit_en = paddr == ISR_OFF_HP_EN;
	assign hit_cause = paddr == ISR_OFF_HP_CAUSE;
	assign hit_std = paddr == ISR_OFF_STD_EN;
	assign hit_ta = paddr == ISR_OFF_TADDR;
	assign ok = hit_en | hit_cause | hit_std | hit_ta;

	// ==========================================================
	// Register state
	logic [15:0] hp_en_q;
	logic [15:0] std_en_q;
	logic [15:0] cause_q;
	logic [15:0] cause_d;
	logic [15:0] cause_set;
	logic [15:0] cause_clr;
	logic [15:0] ta_q;
	logic [15:0] ta_wmask;
	logic [15:0] rd_word;
	logic strap_q;
	logic tf_int_q;

	// ==========================================================
	// Enable registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hp_en_q <= ISR_HP_EN_RST;
		end else if (wr_acc & hit_en) begin
			hp_en_q <= pwdata[15:0] & ISR_HP_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			std_en_q <= ISR_STD_EN_RST;
		end else if (wr_acc & hit_std) begin
			std_en_q <= pwdata[15:0] & ISR_STD_MASK;
		end
	end

	// ==========================================================
	// Standard event qualification, one term per source, except block and descriptor, which share one term
	logic ev_illbc;
	logic ev_illcmd;
	logic ev_poll;
	logic ev_retry;
	logic ev_msgerr;
	logic ev_icb;
	logic ev_block;
	logic std_evt;
	logic std_hp_set;
	logic std_pin_low;
	assign ev_illbc = rt_mode & std_ev.illegal_bcast & std_en_q[ISR_S_ILLBC];
	assign ev_illcmd = rt_mode & std_ev.illegal_cmd & std_en_q[ISR_S_ILLCMD];
	// Poll match also needs the command block's own enable
	assign ev_poll = bc_mode & std_ev.poll_match & std_ev.poll_cb_en & std_en_q[ISR_S_POLL];
	assign ev_retry = bc_mode & std_ev.retry_fail & std_en_q[ISR_S_RETRY];
	assign ev_msgerr = std_ev.msg_error & std_en_q[ISR_S_MSGERR];
	assign ev_icb = (bc_mode | mon_mode) & std_ev.icb_done & std_en_q[ISR_S_ICBC];
	// Block and descriptor enables bypass the enable register
	assign ev_block = std_ev.cb_std | std_ev.desc_std;
	assign std_evt = ev_illbc | ev_illcmd | ev_poll | ev_retry | ev_msgerr | ev_icb | ev_block;
	assign std_hp_set = std_evt & hp_en_q[ISR_B_STD];
	assign std_pin_low = (std_evt & ~hp_en_q[ISR_B_STD]) | cause_d[ISR_B_STD];

	// ==========================================================
	// Cause register; a set in the same cycle as its clear wins
	always_comb begin
		cause_set = 16'h0000;
		cause_set[8:1] = hp_event & hp_en_q[8:1];
		cause_set[ISR_B_STD] = std_hp_set;
	end

	assign cause_clr = (wr_acc & hit_cause) ? pwdata[15:0] : 16'h0000;

	generate
		for (genvar gi = 0; gi < 16; gi++) begin : g_cause
			// Reserved positions never hold a cause
			assign cause_d[gi] = ISR_HP_MASK[gi] & (cause_set[gi] | (cause_q[gi] & ~cause_clr[gi]));
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cause_q <= 16'h0000;
		end else begin
			cause_q <= cause_d;
		end
	end

	// ==========================================================
	// Interrupt outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			std_irq_n_pin <= 1'b1;
		end else begin
			// Held low while cause bit 0 stands, else a one-cycle pulse
			std_irq_n_pin <= ~std_pin_low;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hp_irq_n <= 1'b1;
		end else begin
			hp_irq_n <= ~(|cause_d[8:1]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			std_log <= 1'b0;
		end else begin
			std_log <= std_evt;
		end
	end

	// ==========================================================
	// Terminal address register; straps caught at the first edge after reset
	logic [4:0] chk_addr;
	logic chk_par;
	logic par_err;
	// Lock protects only the address field; flag bits stay writable
	assign ta_wmask = lock_pin ? 16'hfe00 : 16'hfe1f;
	assign chk_addr = strap_q ? terminal_addr_pins : ta_q[4:0];
	assign chk_par = strap_q ? terminal_par_pin : ta_q[ISR_T_PAR];
	assign par_err = ~(^{chk_addr, chk_par});

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_q <= 1'b1;
		end else begin
			strap_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ta_q <= ISR_TADDR_RST;
		end else begin
			if (strap_q) begin
				ta_q[4:0] <= terminal_addr_pins;
				ta_q[ISR_T_PAR] <= terminal_par_pin;
			end else if (wr_acc & hit_ta) begin
				ta_q <= (ta_q & ~ta_wmask) | (pwdata[15:0] & ta_wmask);
			end
			// Error bit is outside the write mask; set here only at strap or address latch
			if (strap_q | addr_latch) begin
				ta_q[ISR_T_PERR] <= par_err;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tf_int_q <= 1'b0;
		end else if (selftest_fail) begin
			// Self-test failure wins over a same-cycle host write
			tf_int_q <= 1'b1;
		end else if (wr_acc & hit_ta) begin
			tf_int_q <= 1'b0;
		end
	end

	// ==========================================================
	// Status word flags to the protocol engine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_flags.instr <= 1'b0;
		end else begin
			status_flags.instr <= ta_q[ISR_T_INSTR];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_flags.srq <= 1'b0;
		end else begin
			status_flags.srq <= ta_q[ISR_T_SRQ];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_flags.busy <= 1'b0;
		end else begin
			status_flags.busy <= ta_q[ISR_T_BUSY] | ta_q[ISR_T_BUSYX];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_flags.block_xfer <= 1'b0;
		end else begin
			status_flags.block_xfer <= ta_q[ISR_T_BUSYX];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_flags.ss_flag <= 1'b0;
		end else begin
			status_flags.ss_flag <= ta_q[ISR_T_SSF];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ss_fail_log <= 1'b0;
		end else begin
			ss_fail_log <= rt_mode & ta_q[ISR_T_SSF];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_flags.dbc_accept <= 1'b0;
		end else begin
			status_flags.dbc_accept <= ta_q[ISR_T_DBCA] & dbc_code_rx;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_flags.term_flag <= 1'b0;
		end else begin
			status_flags.term_flag <= ta_q[ISR_T_TF] | tf_int_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			terminal_addr <= 5'h00;
		end else begin
			terminal_addr <= ta_q[4:0];
		end
	end

	// ==========================================================
	// Read path; no wait state, prdata registered from a flip-flop in the setup phase
	always_comb begin
		rd_word = 16'h0000;
		case (paddr)
			ISR_OFF_HP_EN: begin
				rd_word = hp_en_q;
			end
			ISR_OFF_HP_CAUSE: begin
				rd_word = cause_q;
			end
			ISR_OFF_STD_EN: begin
				rd_word = std_en_q;
			end
			ISR_OFF_TADDR: begin
				rd_word = {ta_q[15:9], role_select_pin, lock_pin, ta_q[6:0]};
			end
			default: begin
				rd_word = 16'h0000;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= setup_acc;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= setup_acc & ~ok;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (setup_acc & ~pwrite) begin
			prdata <= {16'h0000, rd_word};
		end else begin
			prdata <= 32'h00000000;
		end
	end
endmodule

// [test/isr_host.sv]
// Host model: APB master issuing register reads and writes
`timescale 1ns/1ps
module isr_host (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = '0;
		pwdata = '0;
	end
	// Answer taken at the rising edge that samples pready; only then is the request released
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
endmodule

// [test/isr_regs_properties.sv]
// Checker: bus timing, cause hold and terminal flag properties
`timescale 1ns/1ps
module isr_chk
	import isr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic lock_pin,
	input wire logic hp_irq_n,
	input wire isr_status_s status_flags,
	input wire logic [4:0] terminal_addr
);
	logic wc;
	assign wc = psel && penable && pready && pwrite && paddr == ISR_OFF_HP_CAUSE;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_acc; psel && penable && pready; endsequence
	sequence s_ta; s_acc ##0 pwrite && paddr == ISR_OFF_TADDR; endsequence
	property p_rdy; psel && !penable |=> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready after setup");
	property p_slv; psel && !penable && !(paddr inside {8'h1c, 8'h20, 8'h24, 8'h28}) |=> pslverr; endproperty
	a_slv: assert property (p_slv) else $error("unmapped access not refused");
	property p_rsv; s_acc ##0 !pwrite && paddr == ISR_OFF_HP_CAUSE |-> prdata[31:9] == 23'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved cause bits set");
	// Clear may lag the write by one edge
	property p_hold; !hp_irq_n && !wc && !$past(wc) |=> !hp_irq_n; endproperty
	a_hold: assert property (p_hold) else $error("cause output dropped without clear");
	// Address and flags reach the outputs one edge after the register
	property p_lock; s_ta ##0 lock_pin |=> ##1 $stable(terminal_addr); endproperty
	a_lock: assert property (p_lock) else $error("address changed under lock");
	property p_addr; s_ta ##0 !lock_pin |=> ##1 terminal_addr == $past(pwdata[4:0], 2); endproperty
	a_addr: assert property (p_addr) else $error("address write lost");
	property p_flag; s_ta |=> ##1 status_flags.instr == $past(pwdata[15], 2)
		&& status_flags.srq == $past(pwdata[10], 2) && status_flags.ss_flag == $past(pwdata[13], 2); endproperty
	a_flag: assert property (p_flag) else $error("status flag mismatch");
	property p_busy; s_ta |=> ##1 status_flags.busy == ($past(pwdata[14], 2) | $past(pwdata[9], 2))
		&& status_flags.block_xfer == $past(pwdata[9], 2); endproperty
	a_busy: assert property (p_busy) else $error("busy flag mismatch");
endmodule
bind isr_regs isr_chk c_u (.*);

// [test/tb_isr_regs.sv]
// Testbench: register access, events and terminal flags
`timescale 1ns/1ps
module tb_isr_regs;
	import isr_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, std_irq_n_pin, hp_irq_n, std_log, ss_fail_log;
	logic rt_mode, bc_mode, mon_mode, dbc_code_rx, selftest_fail, addr_latch, role_select_pin, lock_pin, terminal_par_pin;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [8:1] hp_event;
	logic [4:0] terminal_addr_pins, terminal_addr;
	isr_std_ev_s std_ev;
	isr_status_s status_flags;
	logic [8:0] ev[6] = '{9'h004, 9'h008, 9'h010, 9'h060, 9'h080, 9'h100};
	logic [15:0] fw[5] = '{16'h8400, 16'h4000, 16'h0200, 16'h2800, 16'h1000};
	logic [6:0] fx[5] = '{7'h42, 7'h20, 7'h21, 7'h14, 7'h08};
	int n_errors = 0, compares = 0, cyc = 0;
	isr_regs dut_u (.*);
	isr_host h_u (.*);
	initial begin
		pclk = 0;
		forever #2.5 pclk = ~pclk;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic pulse(input logic [8:1] h, input logic [8:0] s);
		@(posedge pclk);
		hp_event <= h;
		std_ev <= s;
		@(posedge pclk);
		hp_event <= '0;
		std_ev <= '0;
		#1;
	endtask
	task automatic tally_and_finish();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge pclk) if (++cyc == 3000) begin
		n_errors++;
		tally_and_finish();
	end
	initial begin
		{presetn, hp_event, std_ev, bc_mode, mon_mode, dbc_code_rx, selftest_fail, addr_latch, lock_pin} = '0;
		{rt_mode, role_select_pin, terminal_par_pin, terminal_addr_pins} = {3'b110, 5'h15};
		repeat (8) @(posedge pclk);
		presetn <= 1;
		repeat (2) @(posedge pclk);
		#1 chk("pins", 32'h15, 32'(terminal_addr));
		h_u.xfer(0, ISR_OFF_TADDR, 0, rd, er);
		chk("taddr", 32'h0115, rd);
		foreach (fw[i]) begin
			dbc_code_rx <= i == 4;
			h_u.xfer(1, ISR_OFF_TADDR, 32'(fw[i]), rd, er);
			@(posedge pclk);
			#1 chk("flags", 32'(fx[i]), 32'(status_flags));
			chk("ss log", 32'(fw[i][13]), 32'(ss_fail_log));
		end
		@(posedge pclk) selftest_fail <= 1;
		@(posedge pclk) selftest_fail <= 0;
		@(posedge pclk);
		#1 chk("self flag", 32'h0c, 32'(status_flags));
		lock_pin <= 1;
		h_u.xfer(1, ISR_OFF_TADDR, 32'h3, rd, er);
		h_u.xfer(0, ISR_OFF_TADDR, 0, rd, er);
		chk("locked", 32'h0180, rd);
		lock_pin <= 0;
		h_u.xfer(1, ISR_OFF_TADDR, 32'h14, rd, er);
		addr_latch <= 1;
		@(posedge pclk) addr_latch <= 0;
		h_u.xfer(0, ISR_OFF_TADDR, 0, rd, er);
		chk("parity", 32'h0154, rd);
		h_u.xfer(0, 8'h3c, 0, rd, er);
		chk("slverr", 32'h1, 32'(er));
		h_u.xfer(1, ISR_OFF_HP_EN, 32'h1fe, rd, er);
		pulse(8'h81, 0);
		chk("hp out", 0, 32'(hp_irq_n));
		h_u.xfer(0, ISR_OFF_HP_CAUSE, 0, rd, er);
		chk("cause", 32'h0102, rd);
		h_u.xfer(1, ISR_OFF_HP_CAUSE, 32'hffff_fefe, rd, er);
		h_u.xfer(0, ISR_OFF_HP_CAUSE, 0, rd, er);
		chk("cause", 32'h0100, rd);
		h_u.xfer(1, ISR_OFF_HP_CAUSE, 32'h0100, rd, er);
		@(posedge pclk);
		#1 chk("hp out", 1, 32'(hp_irq_n));
		h_u.xfer(1, ISR_OFF_STD_EN, 32'hffff, rd, er);
		h_u.xfer(0, ISR_OFF_STD_EN, 0, rd, er);
		chk("std en", 32'h003f, rd);
		foreach (ev[i]) begin
			h_u.xfer(1, ISR_OFF_STD_EN, 32'h1 << i, rd, er);
			rt_mode <= i > 3;
			bc_mode <= i > 0 && i <= 3;
			mon_mode <= i == 0;
			pulse(0, ev[i]);
			chk("log", 32'h3, {std_log, ~std_irq_n_pin});
		end
		h_u.xfer(1, ISR_OFF_STD_EN, 32'h8, rd, er);
		rt_mode <= 0;
		bc_mode <= 1;
		pulse(0, 9'h040);
		chk("no log", 0, 32'(std_log));
		h_u.xfer(0, ISR_OFF_HP_CAUSE, 0, rd, er);
		chk("cause", 0, rd);
		h_u.xfer(1, ISR_OFF_HP_EN, 32'h1ff, rd, er);
		h_u.xfer(1, ISR_OFF_STD_EN, 32'h2, rd, er);
		pulse(0, 9'h008);
		h_u.xfer(0, ISR_OFF_HP_CAUSE, 0, rd, er);
		chk("std pin", 0, 32'(std_irq_n_pin));
		chk("std cause", 32'h1, rd);
		h_u.xfer(1, ISR_OFF_HP_CAUSE, 32'h1, rd, er);
		@(posedge pclk);
		#1 chk("std pin", 1, 32'(std_irq_n_pin));
		tally_and_finish();
	end
endmodule
